/* core/flash_status_protect_monitor.sv */
// flash auto-operation status, memory kind and block protect monitor
//
// What this block does
// - while an automatic operation runs the ready flag at status bit 0 reads 0.
// - a successful end sets the ready flag to 1 and the next command is taken.
// - a faulty end leaves the ready flag at 0 instead of returning to ready.
// - reset forces the ready flag back to 1, clearing a stuck busy state.
// - status bit 2 shows the memory kind after reset, 0 for flash and 1 for mask ROM.
// - status bits 7 to 4 hold one protect flag per block, each independent of the others.
// - a program operation aimed at a block whose protect flag is 1 is refused.
`timescale 1ns/1ns
module flash_status_protect_monitor
  import flash_status_pkg::*;
(
  // clock, reset, enable
  input  wire logic                                 clk_in,
  input  wire logic                                 resetn_in,
  input  wire logic                                 ce_in,
  // register port
  input  wire logic [flash_status_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic [flash_status_pkg::DATA_W-1:0]  wdata_in,
  input  wire logic                                 wr_in,
  input  wire logic                                 rd_in,
  output logic      [flash_status_pkg::DATA_W-1:0]  rdata_out,
  // flash array side
  input  wire logic                                 op_done_in,
  input  wire logic                                 op_fail_in,
  input  wire logic                                 memory_kind_in,
  input  wire logic [flash_status_pkg::BLOCK_N-1:0] block_lock_in,
  output logic                                      op_start_out,
  output logic                                      op_prog_out,
  output logic      [flash_status_pkg::BLOCK_W-1:0] op_block_out,
  output logic                                      op_abort_out,
  output logic                                      op_refused_out,
  output logic                                      aux_control_out
);

  import flash_status_pkg::*;

  // state
  op_state_t          state_r;
  op_state_t          state_nxt;
  logic               auto_op_done_flag;
  logic               memory_kind_bit_r;
  logic               kind_taken_r;
  logic               aux_control_bit_r;
  logic               start_r;
  logic               prog_r;
  logic [BLOCK_W-1:0] blk_r;
  logic               abort_r;
  logic               refused_r;
  logic               last_refused_r;
  logic [DATA_W-1:0]  rdata_r;
  logic [BLOCK_N-1:0] block_lock_flags;

  // decode
  wire                sel_aux     = (addr_in == AUX_CTRL_ADDR);
  wire                sel_status  = (addr_in == STATUS_ADDR);
  wire                sel_cmd     = (addr_in == CMD_ADDR);
  wire                cmd_wr      = wr_in && sel_cmd;
  wire                aux_wr      = wr_in && sel_aux;
  wire                cmd_go      = cmd_wr && wdata_in[CMD_GO_BIT];
  wire                cmd_prog    = wdata_in[CMD_PROG_BIT];
  wire [BLOCK_W-1:0]  cmd_blk     = wdata_in[CMD_BLK_LSB +: BLOCK_W];
  wire                cmd_reset   = cmd_wr && wdata_in[CMD_RST_BIT];
  wire                blk_locked;
  wire                is_idle     = (state_r == OP_IDLE);
  // program into a protected block is dropped
  wire                go_refused  = cmd_go && !cmd_reset && cmd_prog && blk_locked;
  // commands start only from ready
  wire                go_accept   = cmd_go && !cmd_reset && is_idle && !go_refused;

  flash_lock_bank u_lock (
    .clk_in         (clk_in),
    .resetn_in      (resetn_in),
    .ce_in          (ce_in),
    .lock_src_in    (block_lock_in),
    .blk_sel_in     (cmd_blk),
    .lock_flags_out (block_lock_flags),
    .blk_locked_out (blk_locked)
  );

  // ready flag tracks the state
  assign auto_op_done_flag = is_idle;

  // status word
  wire [DATA_W-1:0] status_word = {{(DATA_W-ST_LOCK_LSB-BLOCK_N){1'b0}},
                                   block_lock_flags,
                                   1'b0,
                                   memory_kind_bit_r,
                                   1'b0,
                                   auto_op_done_flag};
  wire [DATA_W-1:0] aux_word    = {{(DATA_W-1){1'b0}}, aux_control_bit_r};
  wire [DATA_W-1:0] cmd_word    = {{(DATA_W-CMD_REFUSED_BIT-1){1'b0}}, last_refused_r,
                                   {(CMD_REFUSED_BIT-CMD_BLK_LSB-BLOCK_W){1'b0}}, blk_r,
                                   {(CMD_BLK_LSB-CMD_PROG_BIT-1){1'b0}}, prog_r, 1'b0};
  wire [DATA_W-1:0] read_mux    = sel_status ? status_word :
                                  sel_aux    ? aux_word    :
                                  sel_cmd    ? cmd_word    : RDATA_RST;

  // operation sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      OP_IDLE: begin
        if (go_accept) begin
          state_nxt = OP_RUN;
        end
      end
      OP_RUN: begin
        if (cmd_reset) begin
          state_nxt = OP_IDLE;
        end else if (op_fail_in) begin
          state_nxt = OP_STUCK;
        end else if (op_done_in) begin
          state_nxt = OP_IDLE;
        end
      end
      OP_STUCK: begin
        // only a reset command or a reset leaves here
        if (cmd_reset) begin
          state_nxt = OP_IDLE;
        end
      end
      default: begin
        state_nxt = OP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_r <= OP_IDLE;
    end else if (ce_in) begin
      state_r <= state_nxt;
    end
  end

  // command outputs
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      start_r   <= 1'b0;
      abort_r   <= 1'b0;
      refused_r <= 1'b0;
    end else if (ce_in) begin
      start_r   <= go_accept;
      abort_r   <= cmd_reset && !is_idle;
      refused_r <= go_refused;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      prog_r         <= 1'b0;
      blk_r          <= '0;
      last_refused_r <= 1'b0;
    end else if (ce_in) begin
      if (go_accept) begin
        prog_r <= cmd_prog;
        blk_r  <= cmd_blk;
      end
      if (cmd_go && !cmd_reset) begin
        last_refused_r <= go_refused;
      end
    end
  end

  // memory kind caught on the first enabled cycle after reset
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      memory_kind_bit_r <= KIND_RST;
      kind_taken_r      <= 1'b0;
    end else if (ce_in && !kind_taken_r) begin
      memory_kind_bit_r <= memory_kind_in;
      kind_taken_r      <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      aux_control_bit_r <= AUX_RST;
    end else if (ce_in && aux_wr) begin
      aux_control_bit_r <= wdata_in[AUX_BIT];
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rdata_r <= RDATA_RST;
    end else if (ce_in) begin
      rdata_r <= rd_in ? read_mux : RDATA_RST;
    end
  end

  assign rdata_out       = rdata_r;
  assign op_start_out    = start_r;
  assign op_prog_out     = prog_r;
  assign op_block_out    = blk_r;
  assign op_abort_out    = abort_r;
  assign op_refused_out  = refused_r;
  assign aux_control_out = aux_control_bit_r;

  // checks
  AST_BUSY_AFTER_START: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && go_accept |=> !auto_op_done_flag && state_r == OP_RUN)
    else $error("ready flag not cleared when an operation starts");

  AST_STATUS_BUSY_READ: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && rd_in && sel_status && state_r == OP_RUN |=> rdata_out[ST_READY_BIT] == 1'b0)
    else $error("status read shows ready during an operation");

  AST_DONE_READY: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && state_r == OP_RUN && op_done_in && !op_fail_in && !cmd_reset
    |=> auto_op_done_flag)
    else $error("ready flag not set after successful end");

  AST_DONE_ACCEPTS: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && is_idle && cmd_go && !cmd_reset && !go_refused |=> op_start_out)
    else $error("command not taken while ready");

  AST_FAIL_STUCK: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && state_r == OP_RUN && op_fail_in && !cmd_reset
    ##1 (!cmd_reset && !op_done_in) [*2] |-> !auto_op_done_flag)
    else $error("ready flag returned after a faulty end");

  AST_RESET_READY: assert property (@(posedge clk_in) disable iff (!resetn_in)
    resetn_in && !$past(resetn_in) |-> auto_op_done_flag && !op_start_out)
    else $error("ready flag not 1 after reset");

  AST_KIND_HELD: assert property (@(posedge clk_in) disable iff (!resetn_in)
    kind_taken_r && $stable(kind_taken_r) |-> $stable(memory_kind_bit_r))
    else $error("memory kind changed after capture");

  AST_LOCK_MIRROR: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in ##1 resetn_in |-> block_lock_flags == $past(block_lock_in))
    else $error("protect flags do not follow their blocks");

  AST_LOCKED_REFUSED: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && cmd_go && !cmd_reset && cmd_prog && blk_locked
    |=> !op_start_out && op_refused_out && state_r == $past(state_r))
    else $error("program into a protected block was started");

  AST_BUSY_NO_START: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && !is_idle && cmd_go && !cmd_reset |=> !op_start_out)
    else $error("command started while busy");

  AST_START_ONE_CYCLE: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && op_start_out |=> !op_start_out)
    else $error("start pulse longer than one cycle");

  AST_STATUS_READY_READ: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && rd_in && sel_status && is_idle |=> rdata_out[ST_READY_BIT] == 1'b1)
    else $error("status read shows busy while ready");

  AST_START_FROM_READY: assert property (@(posedge clk_in) disable iff (!resetn_in)
    op_start_out && $past(ce_in) |-> $past(is_idle))
    else $error("operation started while not ready");

  AST_STUCK_READ_BUSY: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && rd_in && sel_status && state_r == OP_STUCK |=> rdata_out[ST_READY_BIT] == 1'b0)
    else $error("status read shows ready after a faulty end");

  AST_STUCK_HOLDS: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && state_r == OP_STUCK && !cmd_reset |=> state_r == OP_STUCK)
    else $error("stuck busy state left without a reset");

  AST_FAIL_WINS: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && state_r == OP_RUN && op_fail_in && !cmd_reset |=> state_r == OP_STUCK)
    else $error("faulty end did not leave busy stuck");

  AST_RESET_FORCES_READY: assert property (@(posedge clk_in)
    !resetn_in |=> auto_op_done_flag && !op_start_out && !op_abort_out
    && !op_refused_out)
    else $error("reset did not return to ready");

  AST_RESET_CMD_READY: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && cmd_reset |=> auto_op_done_flag)
    else $error("reset command did not return to ready");

  AST_ABORT_PULSE: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && cmd_reset && !is_idle |=> op_abort_out)
    else $error("reset command while busy gave no abort");

  AST_KIND_READ: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && rd_in && sel_status |=> rdata_out[ST_KIND_BIT] == $past(memory_kind_bit_r))
    else $error("status read shows wrong memory kind");

  AST_LOCK_READ: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && rd_in && sel_status |=> rdata_out[ST_LOCK_LSB +: BLOCK_N] == $past(block_lock_flags))
    else $error("status read shows wrong protect flags");

  AST_STATUS_SPARE_ZERO: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && rd_in && sel_status |=> rdata_out[DATA_W-1:ST_LOCK_LSB+BLOCK_N] == '0
    && rdata_out[3] == 1'b0 && rdata_out[1] == 1'b0)
    else $error("unused status bits not zero");

  AST_REFUSE_RECORDED: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && go_refused |=> last_refused_r && op_refused_out)
    else $error("refused program not recorded");

endmodule : flash_status_protect_monitor

/* core/flash_status_pkg.sv */
// constants shared by the flash status and protect monitor
package flash_status_pkg;

  // register bus shape
  localparam int ADDR_W  = 32;
  localparam int DATA_W  = 32;
  localparam int BLOCK_N = 4;
  localparam int BLOCK_W = 2;

  // byte addresses
  localparam logic [ADDR_W-1:0] AUX_CTRL_ADDR = 32'hFFFF_E518;
  localparam logic [ADDR_W-1:0] STATUS_ADDR   = 32'hFFFF_E520;
  localparam logic [ADDR_W-1:0] CMD_ADDR      = 32'hFFFF_E524;

  // status register fields
  localparam int ST_READY_BIT = 0;
  localparam int ST_KIND_BIT  = 2;
  localparam int ST_LOCK_LSB  = 4;

  // aux control register fields
  localparam int AUX_BIT = 0;

  // command register fields
  localparam int CMD_GO_BIT      = 0;
  localparam int CMD_PROG_BIT    = 1;
  localparam int CMD_BLK_LSB     = 4;
  localparam int CMD_RST_BIT     = 8;
  localparam int CMD_REFUSED_BIT = 16;

  // values after reset
  localparam logic                 READY_RST  = 1'b1;
  localparam logic                 KIND_RST   = 1'b0;
  localparam logic [BLOCK_N-1:0]   LOCK_RST   = 4'h0;
  localparam logic                 AUX_RST    = 1'b0;
  localparam logic [DATA_W-1:0]    RDATA_RST  = 32'h0000_0000;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_RUN,
    OP_STUCK
  } op_state_t;

endpackage : flash_status_pkg

/* core/flash_lock_bank.sv */
// per-block protect flag bank with a lock lookup for one block
`timescale 1ns/1ns
module flash_lock_bank
  import flash_status_pkg::*;
(
  // clock and reset
  input  wire logic                                clk_in,
  input  wire logic                                resetn_in,
  input  wire logic                                ce_in,
  // protect state from the flash array
  input  wire logic [flash_status_pkg::BLOCK_N-1:0] lock_src_in,
  // lookup
  input  wire logic [flash_status_pkg::BLOCK_W-1:0] blk_sel_in,
  output logic      [flash_status_pkg::BLOCK_N-1:0] lock_flags_out,
  output logic                                      blk_locked_out
);

  logic [BLOCK_N-1:0] flag_r;

  // each flag follows its own block, any mix allowed
  genvar g;
  generate
    for (g = 0; g < BLOCK_N; g = g + 1) begin : g_blk
      always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
          flag_r[g] <= LOCK_RST[g];
        end else if (ce_in) begin
          flag_r[g] <= lock_src_in[g];
        end
      end
    end
  endgenerate

  assign lock_flags_out = flag_r;
  assign blk_locked_out = flag_r[blk_sel_in];

endmodule : flash_lock_bank

/* tb/flash_array_model.sv */
// flash array model answering launched auto operations after a fixed delay
`timescale 1ns/1ns
module flash_array_model
  import flash_status_pkg::*;
#(
  parameter int OP_CYCLES = 4
)
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic resetn_in,
  // operation link
  input  wire logic op_start_in,
  input  wire logic fail_mode_in,
  output logic      op_done_out,
  output logic      op_fail_out
);
  logic [7:0] cnt_r;
  wire        fin = (cnt_r == 8'h01);

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cnt_r       <= 8'h00;
      op_done_out <= 1'b0;
      op_fail_out <= 1'b0;
    end else begin
      cnt_r       <= op_start_in ? 8'(OP_CYCLES) : (cnt_r != 8'h00 ? cnt_r - 8'h01 : 8'h00);
      op_done_out <= fin && !fail_mode_in;
      op_fail_out <= fin && fail_mode_in;
    end
  end
endmodule : flash_array_model

/* tb/tb.sv */
// register level test of the flash status and protect monitor
`timescale 1ns/1ns
module tb;
  import flash_status_pkg::*;
  logic              clk_in = 1'b0;
  logic              resetn_in = 1'b0;
  logic [ADDR_W-1:0] addr_in = '0;
  logic [DATA_W-1:0] wdata_in = '0;
  logic              wr_in = 1'b0;
  logic              rd_in = 1'b0;
  logic              kind_in = 1'b1;
  logic [3:0]        lock_in = 4'hA;
  logic              fail_mode = 1'b0;
  logic [DATA_W-1:0] rdata_out;
  logic              done_w;
  logic              fail_w;
  logic              start_w;
  logic              ce = 1'b1;
  logic              refused_w;
  logic              abort_w;
  logic              prog_w;
  logic              aux_w;
  logic [1:0]        blk_w;
  logic [DATA_W-1:0] d;
  int                errors = 0;
  int                comparisons = 0;
  int                starts = 0;
  int                refusals = 0;
  int                aborts = 0;

  always #5 clk_in = ~clk_in;

  // count one-cycle pulses mid-cycle, where they are settled
  always @(negedge clk_in) begin
    if (start_w === 1'b1) starts++;
    if (refused_w === 1'b1) refusals++;
    if (abort_w === 1'b1) aborts++;
  end

  flash_status_protect_monitor flash_status_protect_monitor_i (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .op_done_in(done_w), .op_fail_in(fail_w), .memory_kind_in(kind_in),
    .block_lock_in(lock_in), .op_start_out(start_w), .op_prog_out(prog_w),
    .op_block_out(blk_w), .op_abort_out(abort_w), .op_refused_out(refused_w),
    .aux_control_out(aux_w));

  flash_array_model flash_array_model_i (
    .clk_in(clk_in), .resetn_in(resetn_in), .op_start_in(start_w),
    .fail_mode_in(fail_mode), .op_done_out(done_w), .op_fail_out(fail_w));

  task automatic test_done();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [DATA_W-1:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : rd

  function automatic logic [DATA_W-1:0] st(input logic r, k, input logic [3:0] l);
    return {24'h0, l, 1'b0, k, 1'b0, r};
  endfunction : st

  // poll until ready, bounded
  task automatic wait_ready();
    for (int i = 0; i < 20; i++) begin
      rd(STATUS_ADDR);
      if (d[ST_READY_BIT] === 1'b1) return;
    end
    errors++;
    $display("BAD ready_wait expected 1 seen 0");
    test_done();
  endtask : wait_ready

  task automatic do_reset();
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
  endtask : do_reset

  initial begin
    do_reset();
    rd(STATUS_ADDR);
    chk("status_reset", st(1'b1, 1'b1, 4'hA), d);
    rd(AUX_CTRL_ADDR);
    chk("aux_reset", 32'h0000_0000, d);
    wr(AUX_CTRL_ADDR, 32'hFFFF_FFFF);
    rd(AUX_CTRL_ADDR);
    chk("aux_rw", 32'h0000_0001, d);
    chk("aux_pin", 32'h0000_0001, {31'h0000_0000, aux_w});
    @(posedge clk_in);
    ce <= 1'b0;
    wr(AUX_CTRL_ADDR, 32'h0000_0000);
    @(posedge clk_in);
    ce <= 1'b1;
    rd(AUX_CTRL_ADDR);
    chk("aux_frozen", 32'h0000_0001, d);
    rd(32'hFFFF_E51C);
    chk("unmapped", 32'h0000_0000, d);
    wr(STATUS_ADDR, 32'h0000_0000);
    rd(STATUS_ADDR);
    chk("status_ro", st(1'b1, 1'b1, 4'hA), d);
    @(posedge clk_in);
    lock_in <= 4'h5;
    rd(STATUS_ADDR);
    chk("lock_mix", st(1'b1, 1'b1, 4'h5), d);
    wr(CMD_ADDR, 32'h0000_0013);
    rd(STATUS_ADDR);
    chk("prog_free_busy", st(1'b0, 1'b1, 4'h5), d);
    wait_ready();
    chk("prog_done", st(1'b1, 1'b1, 4'h5), d);
    chk("op_target", 32'h0000_0005, {29'h0000_0000, prog_w, blk_w});
    wr(CMD_ADDR, 32'h0000_0003);
    rd(CMD_ADDR);
    chk("prog_locked", 32'h0001_0012, d);
    chk("refusals", 32'h0000_0001, refusals);
    chk("starts_locked", 32'h0000_0001, starts);
    rd(STATUS_ADDR);
    chk("locked_ready", st(1'b1, 1'b1, 4'h5), d);
    wr(CMD_ADDR, 32'h0000_0001);
    rd(STATUS_ADDR);
    chk("erase_busy", st(1'b0, 1'b1, 4'h5), d);
    chk("erase_target", 32'h0000_0000, {29'h0000_0000, prog_w, blk_w});
    wait_ready();
    wr(CMD_ADDR, 32'h0000_0013);
    rd(STATUS_ADDR);
    chk("next_cmd_taken", st(1'b0, 1'b1, 4'h5), d);
    wait_ready();
    @(posedge clk_in);
    fail_mode <= 1'b1;
    wr(CMD_ADDR, 32'h0000_0013);
    repeat (10) @(posedge clk_in);
    rd(STATUS_ADDR);
    chk("fault_stuck", st(1'b0, 1'b1, 4'h5), d);
    // command while busy must not launch anything
    wr(CMD_ADDR, 32'h0000_0001);
    rd(STATUS_ADDR);
    chk("busy_cmd_ignored", st(1'b0, 1'b1, 4'h5), d);
    chk("starts_busy", 32'h0000_0004, starts);
    wr(CMD_ADDR, 32'h0000_0100);
    rd(STATUS_ADDR);
    chk("reset_cmd", st(1'b1, 1'b1, 4'h5), d);
    chk("aborts", 32'h0000_0001, aborts);
    wr(CMD_ADDR, 32'h0000_0013);
    repeat (10) @(posedge clk_in);
    rd(STATUS_ADDR);
    chk("fault_again", st(1'b0, 1'b1, 4'h5), d);
    @(posedge clk_in);
    fail_mode <= 1'b0;
    kind_in <= 1'b0;
    do_reset();
    rd(STATUS_ADDR);
    chk("hw_reset_ready", st(1'b1, 1'b0, 4'h5), d);
    chk("starts_total", 32'h0000_0005, starts);
    chk("aux_after_reset", 32'h0000_0000, {31'h0000_0000, aux_w});
    test_done();
  end
endmodule : tb
